// *** rtl/pmsc_pkg.sv ***
// Shared constants and types of the power-mode state controller.
// Assumes a single 200 MHz clock domain and an active-low async reset.
package pmsc_pkg;

	// ------------------------------------------------------------
	// Sizes and module-stop layout
	// ------------------------------------------------------------
	localparam int NUM_MODULES = 16;
	localparam int XFER_CTRL_IDX = 0;
	localparam logic [NUM_MODULES-1:0] MSTOP_RST = 16'hfffe;
	localparam int DIV_SEL_W = 3;
	localparam int DIV_CNT_W = 5;
	localparam logic [DIV_SEL_W-1:0] SEL_FULL = 3'h0;
	localparam logic [DIV_SEL_W-1:0] SEL_MAX = 3'h5;

	// ------------------------------------------------------------
	// Controller states, one-hot
	// ------------------------------------------------------------
	typedef enum logic [9:0] {
		st_init = 10'h001,
		st_high = 10'h002,
		st_medium = 10'h004,
		st_subact = 10'h008,
		st_sleep = 10'h010,
		st_subsleep = 10'h020,
		st_watch = 10'h040,
		st_sw_standby = 10'h080,
		st_hw_standby = 10'h100,
		st_spare = 10'h200
	} pmsc_state_t;

endpackage

// *** rtl/pmsc_div_if.sv ***
// Carrier between the controller and its medium-speed divider.
// Assumes both ends share the controller clock.
interface pmsc_div_if;
	import pmsc_pkg::*;
	logic [DIV_SEL_W-1:0] sel;
	logic tick;
	modport ctrl (output sel, input tick);
	modport div (input sel, output tick);
endinterface

// *** rtl/pmsc_clkdiv.sv ***
// Medium-speed divider: one enable pulse per 1 to 32 system clocks.
// Assumes sel is stable or changes only between active modes.
module pmsc_clkdiv
	import pmsc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Controller side
	pmsc_div_if.div dv
);

	logic [DIV_CNT_W-1:0] cnt_ff;
	logic [DIV_CNT_W-1:0] mask;
	logic [DIV_SEL_W-1:0] eff_sel;

	// ------------------------------------------------------------
	// Ratio decode; prohibited codes fall back to the slowest ratio
	// ------------------------------------------------------------
	always_comb begin
		eff_sel = (dv.sel > SEL_MAX) ? SEL_MAX : dv.sel;
		mask = DIV_CNT_W'((32'h1 << eff_sel) - 32'h1);
		dv.tick = ((cnt_ff & mask) == mask);
	end

	// Free-running count; the tick is a compare, so no restart glitch
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + 5'h1;
		end
	end

endmodule

// *** rtl/pmsc_top.sv ***
// Power-mode state controller: mode sequencing, clock and module gating.
// Assumes CPU-side requests are synchronous; pins are synchronised here.
//
// Contract
// - After reset: high-speed, all but transfer controller stopped
// - Nine modes; all but high-speed are reduced-power
// - Sleep halts only the CPU; subsleep also halts masters and peripherals
// - Medium speed divides CPU and bus masters together
// - Subactive runs CPU, masters, peripherals from subclock
// - Module stop halts only selected peripheral modules
// - CPU, master and peripheral states may combine
// - Main oscillator runs only in high, medium, sleep, init
// - Standby pin low forces hardware standby from anywhere
// - Init pin low forces reset except in hardware standby
module pmsc_top
	import pmsc_pkg::*;
#(
	parameter int NMOD = NUM_MODULES
)(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Device pins, asynchronous
	input wire logic hw_sleep_pin_n,
	input wire logic chip_init_input_n,
	input wire logic sub_clk_in,
	// CPU requests and mode control bits
	input wire logic sleep_req,
	input wire logic wake_irq,
	input wire logic ctl_ssby,
	input wire logic ctl_pss,
	input wire logic ctl_lson,
	input wire logic ctl_dton,
	input wire logic [DIV_SEL_W-1:0] ctl_speed_sel,
	input wire logic mstop_we,
	input wire logic [NMOD-1:0] mstop_wdata,
	// Mode status
	output pmsc_state_t mode_ff,
	output logic power_down_ff,
	// Clock gating
	output logic main_osc_en_ff,
	output logic sub_osc_en_ff,
	output logic cpu_run_ff,
	output logic bm_clk_en_ff,
	output logic periph_clk_en_ff,
	output logic [NMOD-1:0] mod_stop_ff,
	// Standby effects
	output logic periph_rst_ff,
	output logic cpu_regs_valid_ff,
	output logic ram_retain_ff,
	output logic io_oe_n_ff
);

	pmsc_div_if div_bus ();
	pmsc_state_t nxt_mode;
	logic [1:0] hw_sync_ff;
	logic [1:0] init_sync_ff;
	logic [2:0] sub_sync_ff;
	logic [NMOD-1:0] mstop_mask_ff;
	logic sub_tick;
	logic active;

	// ------------------------------------------------------------
	// Pin synchronisers; the first stage feeds only the second
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hw_sync_ff <= 2'h3;
			init_sync_ff <= 2'h0;
			sub_sync_ff <= 3'h0;
		end else begin
			hw_sync_ff <= {hw_sync_ff[0], hw_sleep_pin_n};
			init_sync_ff <= {init_sync_ff[0], chip_init_input_n};
			sub_sync_ff <= {sub_sync_ff[1:0], sub_clk_in};
		end
	end

	// Subclock rising edge, seen from the synchronised stages only
	assign sub_tick = sub_sync_ff[1] & ~sub_sync_ff[2];
	assign active = (mode_ff == st_high) || (mode_ff == st_medium);

	// ------------------------------------------------------------
	// Medium-speed divider
	// ------------------------------------------------------------
	assign div_bus.sel = ctl_speed_sel;

	pmsc_clkdiv u_div (
		.clock(clock),
		.nrst(nrst),
		.dv(div_bus.div)
	);

	// ------------------------------------------------------------
	// Mode sequencing; standby pin outranks init pin
	// ------------------------------------------------------------
	always_comb begin
		nxt_mode = mode_ff;
		if (!hw_sync_ff[1]) begin
			nxt_mode = st_hw_standby;
		end else if (!init_sync_ff[1] && mode_ff != st_hw_standby) begin
			nxt_mode = st_init;
		end else begin
			case (mode_ff)
				st_init: begin
					nxt_mode = st_high;
				end
				st_hw_standby: begin
					// Leaving hardware standby always passes through reset
					nxt_mode = st_init;
				end
				st_high, st_medium: begin
					if (sleep_req) begin
						if (!ctl_ssby && !ctl_lson) begin
							nxt_mode = st_sleep;
						end else if (ctl_ssby && !ctl_pss && !ctl_lson) begin
							nxt_mode = st_sw_standby;
						end else if (ctl_ssby && ctl_pss && !ctl_dton) begin
							nxt_mode = st_watch;
						end else if (ctl_ssby && ctl_pss && ctl_lson) begin
							nxt_mode = st_subact;
						end
					end else begin
						// Speed select moves between the two active modes
						nxt_mode = (ctl_speed_sel == SEL_FULL) ? st_high
							: st_medium;
					end
				end
				st_subact: begin
					if (sleep_req) begin
						if (!ctl_ssby && ctl_pss && ctl_lson) begin
							nxt_mode = st_subsleep;
						end else if (ctl_ssby && ctl_pss && !ctl_dton) begin
							nxt_mode = st_watch;
						end else if (ctl_ssby && ctl_pss && !ctl_lson) begin
							nxt_mode = st_high;
						end
					end
				end
				st_sleep, st_sw_standby: begin
					if (wake_irq) begin
						nxt_mode = (ctl_speed_sel == SEL_FULL) ? st_high
							: st_medium;
					end
				end
				st_watch: begin
					if (wake_irq) begin
						nxt_mode = ctl_lson ? st_subact : st_high;
					end
				end
				st_subsleep: begin
					if (wake_irq) begin
						nxt_mode = st_subact;
					end
				end
				default: begin
					nxt_mode = st_init;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			mode_ff <= st_init;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// ------------------------------------------------------------
	// Module-stop mask, written only while the CPU runs
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			mstop_mask_ff <= NMOD'(MSTOP_RST);
		end else if (mode_ff == st_init || mode_ff == st_hw_standby) begin
			mstop_mask_ff <= NMOD'(MSTOP_RST);
		end else if (mstop_we && (active || mode_ff == st_subact)) begin
			mstop_mask_ff <= mstop_wdata;
		end
	end

	// ------------------------------------------------------------
	// Clock and gating outputs, registered from the current mode
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			main_osc_en_ff <= 1'b1;
			sub_osc_en_ff <= 1'b1;
			cpu_run_ff <= 1'b0;
			bm_clk_en_ff <= 1'b0;
			periph_clk_en_ff <= 1'b0;
			mod_stop_ff <= NMOD'(MSTOP_RST);
		end else begin
			main_osc_en_ff <= active || mode_ff == st_sleep
				|| mode_ff == st_init;
			sub_osc_en_ff <= !(mode_ff == st_sw_standby
				|| mode_ff == st_hw_standby);
			// Instruction strobe, medium ratio shared with masters
			case (mode_ff)
				st_high: cpu_run_ff <= 1'b1;
				st_medium: cpu_run_ff <= div_bus.tick;
				st_subact: cpu_run_ff <= sub_tick;
				default: cpu_run_ff <= 1'b0;
			endcase
			// Masters keep running through sleep at the selected speed
			case (mode_ff)
				st_high: bm_clk_en_ff <= 1'b1;
				st_medium, st_sleep: bm_clk_en_ff <= div_bus.tick;
				st_subact: bm_clk_en_ff <= sub_tick;
				default: bm_clk_en_ff <= 1'b0;
			endcase
			case (mode_ff)
				st_high, st_medium, st_sleep: periph_clk_en_ff <= 1'b1;
				st_subact: periph_clk_en_ff <= sub_tick;
				default: periph_clk_en_ff <= 1'b0;
			endcase
			// Mask applies in every mode, so it combines freely
			mod_stop_ff <= mstop_mask_ff;
		end
	end

	// ------------------------------------------------------------
	// Standby side effects and reduced-power flag
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			periph_rst_ff <= 1'b1;
			cpu_regs_valid_ff <= 1'b0;
			ram_retain_ff <= 1'b0;
			io_oe_n_ff <= 1'b0;
			power_down_ff <= 1'b1;
		end else begin
			periph_rst_ff <= mode_ff == st_hw_standby
				|| mode_ff == st_init;
			cpu_regs_valid_ff <= mode_ff != st_hw_standby;
			ram_retain_ff <= mode_ff == st_watch || mode_ff == st_subsleep
				|| mode_ff == st_sw_standby
				|| mode_ff == st_hw_standby;
			io_oe_n_ff <= mode_ff == st_hw_standby;
			power_down_ff <= !(mode_ff == st_high
				&& mstop_mask_ff == '0);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	hw_standby_entry_a: assert property (!hw_sync_ff[1] |=>
		mode_ff == st_hw_standby) else $error("standby pin ignored");
	init_entry_a: assert property (hw_sync_ff[1] && !init_sync_ff[1]
		&& mode_ff != st_hw_standby |=> mode_ff == st_init)
		else $error("init pin ignored");
	init_exit_a: assert property (mode_ff == st_init && hw_sync_ff[1]
		&& init_sync_ff[1] |=> mode_ff == st_high ##1
		mod_stop_ff[XFER_CTRL_IDX] == 1'b0)
		else $error("bad reset exit");
	main_osc_a: assert property (mode_ff inside {st_watch, st_subact,
		st_subsleep, st_sw_standby, st_hw_standby} |=> !main_osc_en_ff)
		else $error("main osc running");
	sub_osc_a: assert property (mode_ff inside {st_sw_standby,
		st_hw_standby} |=> !sub_osc_en_ff)
		else $error("subclock running");
	sleep_cpu_a: assert property (mode_ff inside {st_sleep, st_subsleep}
		|=> !cpu_run_ff) else $error("cpu runs in sleep");
	sleep_bm_a: assert property (mode_ff == st_sleep && div_bus.tick
		|=> bm_clk_en_ff && periph_clk_en_ff)
		else $error("sleep stopped masters");
	medium_lock_a: assert property (mode_ff == st_medium |=>
		cpu_run_ff == bm_clk_en_ff) else $error("cpu/bm split");
	subact_clk_a: assert property (mode_ff == st_subact && !sub_tick
		|=> !cpu_run_ff && !periph_clk_en_ff)
		else $error("subactive off subclock");
	mask_write_a: assert property (mstop_we && active && nxt_mode
		!= st_init && nxt_mode != st_hw_standby |=> ##1
		mod_stop_ff == $past(mstop_wdata, 2))
		else $error("mask write lost");
	hw_effects_a: assert property (mode_ff == st_hw_standby |=>
		periph_rst_ff && io_oe_n_ff && ram_retain_ff
		&& !cpu_regs_valid_ff) else $error("standby effects");
	power_flag_a: assert property (mode_ff != st_high |=> power_down_ff)
		else $error("power flag low");

	cov_medium_c: cover property (mode_ff == st_high ##1
		mode_ff == st_medium);
	cov_watch_c: cover property (mode_ff == st_subact ##1
		mode_ff == st_watch);
	cov_subsleep_c: cover property (mode_ff == st_subsleep ##1
		mode_ff == st_subact);
	cov_combo_c: cover property (mode_ff == st_medium
		&& mstop_mask_ff != '0);

endmodule

// *** sim/pmsc_side_model.sv ***
// Far-side model: the subclock crystal and the CPU and peripheral users.
// Assumes the bench clears the tallies before each measuring window.
module pmsc_side_model (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Enables from the controller
	input wire logic cpu_run,
	input wire logic bm_en,
	input wire logic per_en,
	input wire logic clr,
	input wire logic sub_en,
	// Subclock pin and tallies of work done
	output logic sub_clk,
	output int n_cpu,
	output int n_bm,
	output int n_per
);
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// Subclock crystal
	// ------------------------------------------------------------
	// Holds its level while the generator is halted by the controller;
	// 20 system clocks a period keeps the run short
	initial begin
		sub_clk = 1'b0;
		forever #50 sub_clk = sub_en ? ~sub_clk : sub_clk;
	end

	// ------------------------------------------------------------
	// Clock users
	// ------------------------------------------------------------
	// Each enable pulse is one unit of work on that side
	always @(posedge clock) begin
		if (!nrst || clr) begin
			n_cpu <= 0;
			n_bm <= 0;
			n_per <= 0;
		end else begin
			n_cpu <= n_cpu + int'(cpu_run);
			n_bm <= n_bm + int'(bm_en);
			n_per <= n_per + int'(per_en);
		end
	end
endmodule

// *** sim/tb.sv ***
// Self-checking bench of the power-mode state controller.
// Assumes the far-side model supplies the subclock and counts enables.
module tb
	import pmsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] c;
		logic [9:0] m;
		logic mo;
		logic so;
		logic [9:0] w;
	} pmsc_row_t;
	logic clock, nrst, hw_n, init_n, sub_clk, sleep_req, wake_irq;
	logic ssby, pss, lson, dton, mstop_we, clr;
	logic [2:0] spd;
	logic [15:0] wdata, ms;
	pmsc_state_t mode;
	logic pd, mo, so, cr, bm, pe, prst, rv, rr, oe;
	int n_cpu, n_bm, n_per, mismatches, total_checks, cycles;
	// Controls are ssby, pss, lson, dton; requests made from high speed
	// Last field is the mode after a wake with the same controls
	pmsc_row_t rows [5] = '{'{4'h0, st_sleep, 1'b1, 1'b1, st_high},
		'{4'h8, st_sw_standby, 1'b0, 1'b0, st_high},
		'{4'hc, st_watch, 1'b0, 1'b1, st_high},
		'{4'hf, st_subact, 1'b0, 1'b1, st_subact},
		'{4'h2, st_high, 1'b1, 1'b1, st_high}};

	pmsc_top pmsc_top_i (.clock(clock), .nrst(nrst), .hw_sleep_pin_n(hw_n),
		.chip_init_input_n(init_n), .sub_clk_in(sub_clk),
		.sleep_req(sleep_req), .wake_irq(wake_irq), .ctl_ssby(ssby),
		.ctl_pss(pss), .ctl_lson(lson), .ctl_dton(dton),
		.ctl_speed_sel(spd), .mstop_we(mstop_we), .mstop_wdata(wdata),
		.mode_ff(mode), .power_down_ff(pd), .main_osc_en_ff(mo),
		.sub_osc_en_ff(so), .cpu_run_ff(cr), .bm_clk_en_ff(bm),
		.periph_clk_en_ff(pe), .mod_stop_ff(ms), .periph_rst_ff(prst),
		.cpu_regs_valid_ff(rv), .ram_retain_ff(rr), .io_oe_n_ff(oe));
	pmsc_side_model pmsc_side_model_i (.clock(clock), .nrst(nrst),
		.cpu_run(cr), .bm_en(bm), .per_en(pe), .clr(clr),
		.sub_en(so),
		.sub_clk(sub_clk), .n_cpu(n_cpu), .n_bm(n_bm), .n_per(n_per));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Sample a little after the edge so its updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One-cycle request with its control levels
	task automatic req(input logic w, input logic [3:0] c);
		@(posedge clock);
		{ssby, pss, lson, dton} <= c;
		if (w) wake_irq <= 1'b1;
		else sleep_req <= 1'b1;
		@(posedge clock);
		wake_irq <= 1'b0;
		sleep_req <= 1'b0;
		cyc(2);
	endtask
	task automatic wr(input logic [15:0] v);
		@(posedge clock);
		mstop_we <= 1'b1;
		wdata <= v;
		@(posedge clock);
		mstop_we <= 1'b0;
		cyc(3);
	endtask
	task automatic rst();
		@(posedge clock);
		nrst <= 1'b0;
		spd <= 3'h0;
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		cyc(6);
	endtask
	// Tally enable pulses over a window of n cycles
	task automatic measure(input int n);
		@(posedge clock);
		clr <= 1'b1;
		@(posedge clock);
		clr <= 1'b0;
		cyc(n);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// The whole run needs about 600 cycles; a hang stops far later
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			finish_test();
		end
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		{nrst, sleep_req, wake_irq, ssby, pss, lson, dton} = 7'h00;
		{hw_n, init_n, mstop_we, clr, spd, wdata} = {4'hc, 3'h0, 16'h0000};
		cycles = 0;
		repeat (2) @(posedge clock);
		#1;
		chk(mode, st_init);
		chk(prst, 1'b1);
		@(posedge clock);
		nrst <= 1'b1;
		cyc(6);
		chk(mode, st_high);
		chk(ms, 16'hfffe);
		chk(pd, 1'b1);
		$display("test reset done");
		// Every entry of the table starts from a fresh reset
		for (int i = 0; i < 5; i++) begin
			rst();
			req(1'b0, rows[i].c);
			chk(mode, rows[i].m);
			chk(mo, rows[i].mo);
			chk(so, rows[i].so);
			req(1'b1, rows[i].c);
			chk(mode, rows[i].w);
		end
		$display("test mode table done");
		// Divide by 8 must slow CPU and masters alike
		rst();
		@(posedge clock);
		spd <= 3'h3;
		cyc(3);
		chk(mode, st_medium);
		measure(32);
		chk(n_cpu, 4);
		chk(n_bm, 4);
		req(1'b0, 4'h0);
		measure(32);
		chk(n_cpu, 0);
		chk(n_bm, 4);
		chk(n_per, 32);
		wr(16'h00f0);
		chk(ms, 16'hfffe);
		req(1'b1, 4'h0);
		chk(mode, st_medium);
		wr(16'h00f0);
		chk(ms, 16'h00f0);
		chk(mode, st_medium);
		@(posedge clock);
		spd <= 3'h0;
		wr(16'h0000);
		chk(pd, 1'b0);
		$display("test medium and stop done");
		// Subclock modes: one pulse per subclock period of 20 cycles
		rst();
		req(1'b0, 4'hf);
		measure(200);
		chk((n_cpu > 8) && (n_cpu < 12), 1'b1);
		chk((n_bm > 8) && (n_bm < 12), 1'b1);
		chk((n_per > 8) && (n_per < 12), 1'b1);
		req(1'b0, 4'h6);
		chk(mode, st_subsleep);
		measure(100);
		chk(n_cpu, 0);
		req(1'b1, 4'h6);
		chk(mode, st_subact);
		req(1'b0, 4'he);
		chk(mode, st_watch);
		chk(mo, 1'b0);
		req(1'b1, 4'he);
		chk(mode, st_subact);
		req(1'b0, 4'hd);
		chk(mode, st_high);
		$display("test subclock done");
		// Standby pin wins; the init pin is ignored while in standby
		@(posedge clock);
		hw_n <= 1'b0;
		cyc(4);
		chk(mode, st_hw_standby);
		chk({oe, prst, rv, rr, so}, 5'h1a);
		@(posedge clock);
		init_n <= 1'b0;
		cyc(5);
		chk(mode, st_hw_standby);
		@(posedge clock);
		hw_n <= 1'b1;
		cyc(5);
		chk(mode, st_init);
		@(posedge clock);
		init_n <= 1'b1;
		cyc(6);
		chk(mode, st_high);
		wr(16'h0000);
		@(posedge clock);
		spd <= 3'h1;
		cyc(3);
		@(posedge clock);
		init_n <= 1'b0;
		cyc(4);
		chk(mode, st_init);
		// Mask reloads one edge after the mode, stop outputs one more
		cyc(1);
		chk(ms, 16'hfffe);
		$display("test pins done");
		finish_test();
	end
endmodule
